// >>> logic/sao_map.vh
`ifndef SAO_MAP_VH
`define SAO_MAP_VH
// =====================================================================
// Register indices (byte address is four times the index)
// =====================================================================
`define IDX_CORE_CONTROL 14'h081c
`define IDX_PORT_STATUS 14'h081d
`define IDX_SERIAL_OUTPUT_CONTROL 14'h081e
// =====================================================================
// Reset values and writable masks
// =====================================================================
`define RST_CORE_CONTROL 2'h0
`define RST_SERIAL_OUTPUT_CONTROL 16'h0000
`define MASK_SERIAL_OUTPUT_CONTROL 16'h3fff
// =====================================================================
// Output control field positions
// =====================================================================
`define F_WCLK_POL 13
`define F_BCLK_EDGE 12
`define F_MASTER 11
`define F_BDIV_HI 10
`define F_BDIV_LO 9
`define F_WDIV_HI 8
`define F_WDIV_LO 7
`define F_FSYNC 6
`define F_TDM 5
`define F_MSB_HI 4
`define F_MSB_LO 2
`define F_WLEN_HI 1
`define F_WLEN_LO 0
// =====================================================================
// Core rate figures
// =====================================================================
`define PROG_LEN_1X 11'h400
`define PROG_LEN_2X 11'h200
`define PROG_LEN_4X 11'h100
`define CONV_KHZ_1X 8'h30
`define CONV_KHZ_2X 8'h60
`define CONV_KHZ_4X 8'hc0
// Slot length in bit clocks for pulse framing and multiplexed mode.
`define SLOT_BITS 6'h20
`endif

// >>> logic/serial_audio_output_port_ctrl.v
// Implementation choice: the APB slave port.
`timescale 1ns/1ps
`include "sao_map.vh"

// Function
// RL1 - Rate field picks 1024, 512, 256 instructions
// RL2 - Double rate 96 kHz, quadruple 192 kHz
// RL3 - Single rate suits 48 or 44.1 kHz
// RL4 - Sixteen-bit control register, reset zero, layout
// RL5 - Polarity bit decides which half is left
// RL6 - Edge bit picks falling or rising launch
// RL7 - Slave after reset; clocks driven only when master
// RL8 - Master bit clock divides internal clock 16..2
// RL9 - Master word clock divides by 1024, 512, 256
// RL10 - Divider fields act only in master mode
// RL11 - Frame sync: 50% clock or frame pulse
// RL12 - Multiplexed mode sends one stream on pin zero
// RL13 - MSB first, delay by 1, 0, 8, 12, 16
// RL14 - Word length 24, 20, 16; zeros after LSB
// RL15 - Software avoids word divider code three
module serial_audio_output_port_ctrl #(
    parameter NPINS = 4,
    parameter WBITS = 24
) (
    // Clock and reset; the clock stands for the internal 1024 x fs clock.
    input wire clk_in,
    input wire nrst_in,
    // APB slave.
    input wire psel_in,
    input wire penable_in,
    input wire pwrite_in,
    input wire [15:0] paddr_in,
    input wire [31:0] pwdata_in,
    output reg [31:0] prdata_out,
    output wire pready_out,
    output reg pslverr_out,
    // Core rate results.
    output reg [10:0] prog_len_out,
    output reg [7:0] conv_khz_out,
    // Serial clock pins, split into input, output and enable.
    input wire bclk_in,
    output wire bclk_out,
    output wire bclk_oe_out,
    input wire wclk_in,
    output wire wclk_out,
    output wire wclk_oe_out,
    // Sample words, pin i takes bits [i*WBITS +: WBITS].
    input wire [NPINS*WBITS-1:0] left_data_in,
    input wire [NPINS*WBITS-1:0] right_data_in,
    // Serial data pins; pin zero carries the multiplexed stream.
    output wire [NPINS-1:0] sdata_out
);

// =====================================================================
// Register file
// =====================================================================
reg [1:0] core_rate_select_r;
reg [15:0] out_ctrl_r;
wire [13:0] idx = paddr_in[15:2];
wire setup = psel_in & ~penable_in;
wire hit_core = (idx == `IDX_CORE_CONTROL);
wire hit_stat = (idx == `IDX_PORT_STATUS);
wire hit_out = (idx == `IDX_SERIAL_OUTPUT_CONTROL);
wire mapped = hit_core | hit_stat | hit_out;
wire [31:0] status_word;

// Zero wait states: the answer is ready in every access phase.
assign pready_out = 1'b1;

// Writes commit in the access phase; read data is captured at setup.
always @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
        core_rate_select_r <= `RST_CORE_CONTROL;
        out_ctrl_r <= `RST_SERIAL_OUTPUT_CONTROL; // RL4
        prdata_out <= 32'h0000_0000;
        pslverr_out <= 1'b0;
    end else begin
        if (psel_in & penable_in & pwrite_in) begin
            if (hit_core) begin
                core_rate_select_r <= pwdata_in[1:0];
            end
            if (hit_out) begin
                // Top two bits are not stored and read back as zero.
                out_ctrl_r <= pwdata_in[15:0] & `MASK_SERIAL_OUTPUT_CONTROL; // RL4
            end
        end
        if (setup) begin
            pslverr_out <= ~mapped;
            if (pwrite_in | ~mapped) begin
                prdata_out <= 32'h0000_0000;
            end else if (hit_core) begin
                prdata_out <= {30'h0, core_rate_select_r};
            end else if (hit_stat) begin
                prdata_out <= status_word;
            end else begin
                prdata_out <= {16'h0, out_ctrl_r};
            end
        end
    end
end

// =====================================================================
// Core rate decode
// =====================================================================
// Reserved code three falls back to the single-rate figures.
always @* begin
    case (core_rate_select_r) // RL1 RL2
        2'h1: begin
            prog_len_out = `PROG_LEN_2X;
            conv_khz_out = `CONV_KHZ_2X;
        end
        2'h2: begin
            prog_len_out = `PROG_LEN_4X;
            conv_khz_out = `CONV_KHZ_4X;
        end
        default: begin
            prog_len_out = `PROG_LEN_1X;
            conv_khz_out = `CONV_KHZ_1X;
        end
    endcase
end

// =====================================================================
// Control fields
// =====================================================================
wire word_clock_polarity = out_ctrl_r[`F_WCLK_POL];
wire bit_clock_edge_select = out_ctrl_r[`F_BCLK_EDGE];
wire master = out_ctrl_r[`F_MASTER];
wire [1:0] bit_clock_divider = out_ctrl_r[`F_BDIV_HI:`F_BDIV_LO];
wire [1:0] word_clock_divider = out_ctrl_r[`F_WDIV_HI:`F_WDIV_LO];
wire frame_sync_type = out_ctrl_r[`F_FSYNC];
wire tdm = out_ctrl_r[`F_TDM];
wire [2:0] msb_delay = out_ctrl_r[`F_MSB_HI:`F_MSB_LO];
wire [1:0] output_word_length = out_ctrl_r[`F_WLEN_HI:`F_WLEN_LO];

// =====================================================================
// Master clock generation
// =====================================================================
reg [9:0] icnt_r;
reg gen_bclk;
reg gen_half;
reg [9:0] bper;
reg [9:0] wmask;
always @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
        icnt_r <= 10'h000;
    end else begin
        icnt_r <= icnt_r + 10'h001;
    end
end

// A free-running count gives both clocks phase-locked at no extra cost.
always @* begin
    case (bit_clock_divider) // RL8
        2'h0: begin
            gen_bclk = icnt_r[3];
            bper = 10'h010;
        end
        2'h1: begin
            gen_bclk = icnt_r[2];
            bper = 10'h008;
        end
        2'h2: begin
            gen_bclk = icnt_r[1];
            bper = 10'h004;
        end
        default: begin
            gen_bclk = icnt_r[0];
            bper = 10'h002;
        end
    endcase
    // Reserved code three is treated like code zero.
    case (word_clock_divider) // RL9 RL15
        2'h1: begin
            gen_half = icnt_r[8];
            wmask = 10'h1ff;
        end
        2'h2: begin
            gen_half = icnt_r[7];
            wmask = 10'h0ff;
        end
        default: begin
            gen_half = icnt_r[9];
            wmask = 10'h3ff;
        end
    endcase
end

// Pulse framing is high for one bit clock at the start of the frame.
wire gen_pulse = ((icnt_r & wmask) < bper);
wire gen_wclk = frame_sync_type ? gen_pulse : gen_half; // RL11

assign bclk_oe_out = master; // RL7
assign wclk_oe_out = master; // RL7
assign bclk_out = master & gen_bclk; // RL10
assign wclk_out = master & gen_wclk; // RL10

// =====================================================================
// Serialiser
// =====================================================================
// In slave mode the pins are sampled directly; dividers are ignored.
wire bclk_now = master ? gen_bclk : bclk_in; // RL10
wire wclk_now = master ? gen_wclk : wclk_in;
reg bclk_d_r;
reg wclk_d_r;
reg right_r;
reg [2:0] slot_r;
reg [5:0] pos_r;
reg [NPINS-1:0] sd_r;
wire fall = bclk_d_r & ~bclk_now;
wire rise = ~bclk_d_r & bclk_now;
wire launch = bit_clock_edge_select ? rise : fall; // RL6
wire wedge = wclk_now ^ wclk_d_r;
wire frame_start = frame_sync_type & wclk_now & ~wclk_d_r;
wire slot_wrap = (frame_sync_type | tdm) & (pos_r == `SLOT_BITS - 6'h1);
wire new_frame = frame_sync_type ? frame_start : wedge;
wire [5:0] pos_now = new_frame ? 6'h00 :
    (slot_wrap ? 6'h00 : ((pos_r == 6'h3f) ? pos_r : pos_r + 6'h01));
// Side and slot as they stand after this launch, so that the first bit
// of a frame already takes the new word and not the one before it.
// Polarity zero: low word clock carries left data.
wire right_now = new_frame ?
    (frame_sync_type ? 1'b0 : (wclk_now ^ word_clock_polarity)) :
    (slot_wrap ? ~right_r : right_r); // RL5 RL11
wire [2:0] slot_now = new_frame ? 3'h0 :
    (slot_wrap ? slot_r + 3'h1 : slot_r);

// Track half-frame side, multiplexed slot and bit position per launch.
always @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
        bclk_d_r <= 1'b0;
        wclk_d_r <= 1'b0;
        right_r <= 1'b0;
        slot_r <= 3'h0;
        pos_r <= 6'h00;
    end else begin
        bclk_d_r <= bclk_now;
        if (launch) begin
            wclk_d_r <= wclk_now;
            pos_r <= pos_now;
            right_r <= right_now;
            slot_r <= slot_now;
        end
    end
end

// Delay and word length decode; reserved codes take the first choice.
reg [5:0] delay;
reg [5:0] wlen;
always @* begin
    case (msb_delay) // RL13
        3'h1: delay = 6'd0;
        3'h2: delay = 6'd8;
        3'h3: delay = 6'd12;
        3'h4: delay = 6'd16;
        default: delay = 6'd1;
    endcase
    case (output_word_length) // RL14
        2'h1: wlen = 6'd20;
        2'h2: wlen = 6'd16;
        default: wlen = 6'd24;
    endcase
end

wire [5:0] bit_idx = pos_now - delay;
wire bit_valid = (pos_now >= delay) & (bit_idx < wlen); // RL14
wire [4:0] msb_idx = 5'd23 - bit_idx[4:0]; // RL13

// One data path per pin; pin zero switches to slot order when muxed.
genvar gi;
generate
    for (gi = 0; gi < NPINS; gi = gi + 1) begin : g_pin
        wire [2:0] sel = (tdm && gi == 0) ? slot_now :
            {gi[1:0], right_now};
        wire [WBITS-1:0] word = sel[0] ?
            right_data_in[sel[2:1]*WBITS +: WBITS] :
            left_data_in[sel[2:1]*WBITS +: WBITS];
        always @(posedge clk_in or negedge nrst_in) begin
            if (!nrst_in) begin
                sd_r[gi] <= 1'b0;
            end else if (launch) begin
                if (tdm && gi != 0) begin
                    sd_r[gi] <= 1'b0; // RL12
                end else begin
                    sd_r[gi] <= bit_valid & word[msb_idx]; // RL12 RL13 RL14
                end
            end
        end
    end
endgenerate

assign sdata_out = sd_r;
assign status_word = {24'h0, slot_r, right_r, 3'h0, master};

endmodule // serial_audio_output_port_ctrl

// >>> bench/sao_assertions.sv
`timescale 1ns/1ps
// ====================================================================
// Port checks: register bus, rate outputs and clock pins.
module sao_assertions (
    // Clock, reset and bus.
    input wire clk_in,
    input wire nrst_in,
    input wire psel_in,
    input wire penable_in,
    input wire pwrite_in,
    input wire [15:0] paddr_in,
    input wire [31:0] pwdata_in,
    input wire pslverr_out,
    // Rate results and clock pins.
    input wire [10:0] prog_len_out,
    input wire [7:0] conv_khz_out,
    input wire bclk_out,
    input wire bclk_oe_out,
    input wire wclk_out,
    input wire wclk_oe_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (!nrst_in);
    // A committed write to the output control register.
    sequence ctl_wr;
        psel_in && penable_in && pwrite_in && paddr_in == 16'h2078;
    endsequence
    // Setup then access at an address outside the map.
    sequence bad_acc;
        psel_in && !penable_in && paddr_in != 16'h2070 &&
        paddr_in != 16'h2074 && paddr_in != 16'h2078 ##1 penable_in;
    endsequence
    a_rate_pair: assert property (
        prog_len_out == 11'h400 && conv_khz_out == 8'h30 ||
        prog_len_out == 11'h200 && conv_khz_out == 8'h60 ||
        prog_len_out == 11'h100 && conv_khz_out == 8'hc0)
        else $error("rate outputs inconsistent");
    a_master_on: assert property (ctl_wr ##0 pwdata_in[11] |=>
        bclk_oe_out && wclk_oe_out) else $error("master not driving");
    a_slave_off: assert property (ctl_wr ##0 !pwdata_in[11] |=>
        !bclk_oe_out && !wclk_oe_out) else $error("slave still driving");
    a_oe_cause: assert property ($changed(bclk_oe_out) |->
        $past(psel_in && penable_in && pwrite_in &&
        paddr_in == 16'h2078)) else $error("enable moved alone");
    a_slave_quiet: assert property (!bclk_oe_out |->
        !bclk_out && !wclk_out) else $error("clock out in slave");
    a_bclk_half: assert property (bclk_oe_out && $rose(bclk_out) |->
        ##[1:8] ($fell(bclk_out) || !bclk_oe_out))
        else $error("bit clock high too long");
    a_wclk_half: assert property (wclk_oe_out && $rose(wclk_out) |->
        ##[1:512] ($fell(wclk_out) || !wclk_oe_out))
        else $error("word clock high too long");
    a_bad_err: assert property (bad_acc |-> pslverr_out)
        else $error("no error on unmapped");
    a_good_ok: assert property (psel_in && !penable_in &&
        paddr_in == 16'h2078 ##1 penable_in |-> !pslverr_out)
        else $error("error on mapped register");
endmodule // sao_assertions

bind serial_audio_output_port_ctrl sao_assertions u_chk (
    .clk_in(clk_in), .nrst_in(nrst_in), .psel_in(psel_in),
    .penable_in(penable_in), .pwrite_in(pwrite_in),
    .paddr_in(paddr_in), .pwdata_in(pwdata_in),
    .pslverr_out(pslverr_out), .prog_len_out(prog_len_out),
    .conv_khz_out(conv_khz_out), .bclk_out(bclk_out),
    .bclk_oe_out(bclk_oe_out), .wclk_out(wclk_out),
    .wclk_oe_out(wclk_oe_out));

// >>> bench/sao_clock_source.sv
`timescale 1ns/1ps
// ====================================================================
// External clock source for slave mode; stands still at 0 when idle.
module sao_clock_source (
    input wire clk_in,
    input wire run_in,
    output reg bclk_out,
    output reg wclk_out
);
    reg [9:0] cnt_r;
    // Word clock edges fall on bit clock falls, 32 bits a half frame.
    // A shorter half frame would cut a delayed word before its end.
    always @(posedge clk_in) begin
        cnt_r <= run_in ? cnt_r + 10'h1 : 10'h0;
        bclk_out <= run_in & cnt_r[3];
        wclk_out <= run_in & cnt_r[9];
    end
endmodule // sao_clock_source

// >>> bench/testbench.sv
`timescale 1ns/1ps
// ====================================================================
// Self-checking bench for the serial output port control block.
module testbench;
    reg clk_in, nrst_in, psel_in, penable_in, pwrite_in, run;
    reg [15:0] paddr_in;
    reg [31:0] pwdata_in, d;
    reg [95:0] left_data_in, right_data_in;
    wire [31:0] prdata_out;
    wire pready_out, pslverr_out, bclk_out, bclk_oe_out, wclk_out;
    wire wclk_oe_out, src_b, src_w;
    wire [10:0] prog_len_out;
    wire [7:0] conv_khz_out;
    wire [3:0] sdata_out;
    integer n_errors, check_count, seed, i, tw;
    reg [32:0] exp_q[$];
    // Pin levels: whoever has the enable drives the wire.
    wire bpin = bclk_oe_out ? bclk_out : src_b;
    wire wpin = wclk_oe_out ? wclk_out : src_w;
    serial_audio_output_port_ctrl dut (.clk_in(clk_in),
        .nrst_in(nrst_in), .psel_in(psel_in), .penable_in(penable_in),
        .pwrite_in(pwrite_in), .paddr_in(paddr_in),
        .pwdata_in(pwdata_in), .prdata_out(prdata_out),
        .pready_out(pready_out), .pslverr_out(pslverr_out),
        .prog_len_out(prog_len_out), .conv_khz_out(conv_khz_out),
        .bclk_in(bpin), .bclk_out(bclk_out), .bclk_oe_out(bclk_oe_out),
        .wclk_in(wpin), .wclk_out(wclk_out), .wclk_oe_out(wclk_oe_out),
        .left_data_in(left_data_in), .right_data_in(right_data_in),
        .sdata_out(sdata_out));
    sao_clock_source far (.clk_in(clk_in), .run_in(run),
        .bclk_out(src_b), .wclk_out(src_w));
    initial begin
        clk_in = 1'b0;
        forever #5 clk_in = ~clk_in;
    end
    task end_sim;
        begin
            $display("checks %0d mismatches %0d", check_count, n_errors);
            if (n_errors == 0 && check_count > 0)
                $display("Finished cleanly");
            else
                $display("Finished with errors");
            $finish;
        end
    endtask
    task cmp(input [8*8-1:0] nm, input [32:0] e, input [32:0] s);
        begin
            check_count = check_count + 1;
            if (s !== e) begin
                n_errors = n_errors + 1;
                $display("mismatch %0s exp %h got %h", nm, e, s);
            end
        end
    endtask
    // Reads leave their expected {error, data} in the queue.
    task apb(input w, input [15:0] a, input [31:0] dd, input [32:0] e);
        begin
            if (!w)
                exp_q.push_back(e);
            psel_in <= 1'b1;
            pwrite_in <= w;
            paddr_in <= a;
            pwdata_in <= dd;
            @(posedge clk_in);
            penable_in <= 1'b1;
            tw = 0;
            @(posedge clk_in);
            while (pready_out !== 1'b1 && tw < 50) begin
                @(posedge clk_in);
                tw = tw + 1;
            end
            psel_in <= 1'b0;
            penable_in <= 1'b0;
            if (tw >= 50) begin
                n_errors = n_errors + 1;
                end_sim;
            end
            // One idle edge: the write has landed and no strobe is set
            // twice in one time step by a following call.
            @(posedge clk_in);
        end
    endtask
    // The read answer is taken at the edge that ends the access phase.
    always @(posedge clk_in) begin
        if (psel_in && penable_in && pready_out === 1'b1 && !pwrite_in)
            cmp("read", exp_q.size() > 0 ? exp_q.pop_front() :
                33'h1ffffffff, {pslverr_out, prdata_out});
    end
    // Pins are looked at on falling edges, away from the launching edge.
    task wait_pin(input integer wh, input v);
        begin
            @(negedge clk_in);
            tw = tw + 1;
            while ((wh ? wpin : bpin) !== v && tw < 5000) begin
                @(negedge clk_in);
                tw = tw + 1;
            end
            if (tw >= 5000) begin
                n_errors = n_errors + 1;
                end_sim;
            end
        end
    endtask
    task period(input integer wh, input [31:0] ctl, input integer e);
        integer n;
        begin
            apb(1'b1, 16'h2078, ctl, 33'h0);
            wait_pin(wh, 1'b0);
            wait_pin(wh, 1'b1);
            n = tw;
            wait_pin(wh, 1'b0);
            wait_pin(wh, 1'b1);
            cmp("period", e, tw - n);
        end
    endtask
    function [23:0] exp_bits(input [23:0] w, input integer dl, len);
        integer p;
        begin
            exp_bits = 24'h0;
            for (p = dl; p < 24 && p < dl + len; p = p + 1)
                exp_bits[23 - p] = w[23 - p + dl];
        end
    endfunction
    // Bits are taken at the bit clock edge opposite to the launch edge.
    task frame(input [31:0] ctl, input [23:0] w, input integer dl, len);
        reg [23:0] got;
        reg [2:0] oth;
        integer p;
        begin
            run <= ~ctl[11];
            oth = 3'h0;
            apb(1'b1, 16'h2078, ctl, 33'h0);
            wait_pin(1, 1'b1);
            wait_pin(1, 1'b0);
            for (p = 0; p < 24; p = p + 1) begin
                wait_pin(0, ctl[12]);
                wait_pin(0, ~ctl[12]);
                got[23 - p] = sdata_out[0];
                oth = oth | sdata_out[3:1];
            end
            cmp("serial", exp_bits(w, dl, len), got);
            if (ctl[5])
                cmp("others", 33'h0, oth);
            run <= 1'b0;
        end
    endtask
    initial begin
        seed = 32'h74fe0f5b;
        {n_errors, check_count, tw} = 0;
        {nrst_in, psel_in, penable_in, pwrite_in, run} = 5'h0;
        paddr_in = 16'h0;
        pwdata_in = 32'h0;
        left_data_in = {$random(seed), $random(seed), $random(seed)};
        right_data_in = {$random(seed), $random(seed), $random(seed)};
        repeat (6) @(posedge clk_in);
        nrst_in <= 1'b1;
        @(posedge clk_in);
        apb(1'b0, 16'h2078, 32'h0, 33'h0);
        $display("test reset values done");
        for (i = 0; i < 4; i = i + 1) begin
            apb(1'b1, 16'h2070, i, 33'h0);
            cmp("prog",
                i == 1 ? 11'h200 : i == 2 ? 11'h100 : 11'h400, prog_len_out);
            cmp("conv",
                i == 1 ? 8'h60 : i == 2 ? 8'hc0 : 8'h30, conv_khz_out);
        end
        apb(1'b1, 16'h2070, 32'h0, 33'h0);
        $display("test rate codes done");
        for (i = 0; i < 4; i = i + 1) begin
            d = $random(seed);
            d[8] = 1'b0;
            apb(1'b1, 16'h2078, d, 33'h0);
            apb(1'b0, 16'h2078, 32'h0, {1'b0, d & 32'h3fff});
        end
        apb(1'b1, 16'h2080, 32'hffff, 33'h0);
        apb(1'b0, 16'h2080, 32'h0, {1'b1, 32'h0});
        $display("test register access done");
        for (i = 0; i < 4; i = i + 1)
            period(0, 32'h800 | (i << 9), 16 >> i);
        for (i = 0; i < 3; i = i + 1)
            period(1, 32'h800 | (i << 7), 1024 >> i);
        // Pulse framing: the word pin is high for one bit clock.
        apb(1'b1, 16'h2078, 32'h840, 33'h0);
        wait_pin(1, 1'b0);
        wait_pin(1, 1'b1);
        i = tw;
        wait_pin(1, 1'b0);
        cmp("pulse", 16, tw - i);
        $display("test master dividers done");
        frame(32'h804, left_data_in[23:0], 0, 24);
        frame(32'h2802, right_data_in[23:0], 1, 16);
        frame(32'h80e, left_data_in[23:0], 12, 16);
        frame(32'h810, left_data_in[23:0], 16, 24);
        frame(32'h1804, left_data_in[23:0], 0, 24);
        frame(32'h824, left_data_in[23:0], 0, 24);
        frame(32'h9, left_data_in[23:0], 8, 20);
        $display("test serial frames done");
        end_sim;
    end
endmodule // testbench
